// [bench/sosr_queue_model.sv]
`timescale 1ns/1ps
// ****
// Queue source that advances its head on each pop of a non-empty queue without a push.
// ****
module sosr_queue_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic queue_pop,
  output logic [7:0] queue_head,
  output logic queue_empty,
  output logic queue_full,
  output logic [15:0] queue_records,
  output logic [15:0] queue_bytes
);
  logic [7:0] mem [4];
  logic [1:0] rp;
  logic [2:0] cnt;
  // An empty queue shows a pattern, never the last head byte.
  assign queue_head = (cnt == 3'h0) ? ~mem[rp] : mem[rp];
  assign queue_empty = cnt == 3'h0;
  assign queue_full = cnt == 3'h4;
  assign queue_records = {13'h0000, cnt};
  assign queue_bytes = {5'h00, cnt, 8'h00};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rp <= 2'h0;
      cnt <= 3'h0;
    end else if (push) begin
      mem[rp + cnt[1:0]] <= push_data;
      cnt <= cnt + 3'h1;
    end else if (queue_pop && cnt != 3'h0) begin
      rp <= rp + 2'h1;
      cnt <= cnt - 3'h1;
    end
  end
endmodule : sosr_queue_model

// [bench/sosr_regs_tb.sv]
`timescale 1ns/1ps
// ****
// Read-side bench of the output register bank.
// ****
module sosr_regs_tb;
  logic clk, resetn, clk_en, rd_en, rd_valid, sample_strobe, fs, tick, lus, full, empty;
  logic pop, push;
  logic [7:0] rd_addr, rd_data, head, pdat;
  logic [15:0] gyro_y, gyro_z, step_total, thr, rec, byt;
  logic [3:0] evt;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic [7:0] RA [13] = '{8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D,
    8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h40};
  localparam logic [7:0] RE [13] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h10,
    8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] EB [4] = '{8'h20, 8'h10, 8'h08, 8'h01};
  localparam logic [7:0] QD [4] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
  sosr_regs sosr_regs_inst (.clk(clk), .resetn(resetn), .clk_en(clk_en), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .sample_strobe(sample_strobe),
    .gyro_y(gyro_y), .gyro_z(gyro_z), .step_total(step_total), .frame_sync_input(fs),
    .output_sample_rate_tick(tick), .pll_ready_evt(evt[0]), .soft_reset_done_evt(evt[1]),
    .data_ready_evt(evt[2]), .gain_ready_evt(evt[3]), .level_unit_select(lus),
    .queue_records(rec), .queue_bytes(byt), .queue_threshold(thr), .queue_full(full),
    .queue_empty(empty), .queue_head(head), .queue_pop(pop));
  sosr_queue_model sosr_queue_model_inst (.clk(clk), .resetn(resetn), .push(push),
    .push_data(pdat), .queue_pop(pop), .queue_head(head), .queue_empty(empty),
    .queue_full(full), .queue_records(rec), .queue_bytes(byt));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end
  task finish_test;
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task rd(input logic [7:0] a, input logic [7:0] e);
    rd_addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    checked++;
    if (rd_valid !== 1'b1 || rd_data !== e) begin
      errors++;
      $display("mismatch %0t addr %h got %h want %h", $time, a, rd_data, e);
    end
    @(negedge clk);
  endtask : rd
  task t_reset;
    for (int i = 0; i < 13; i++) rd(RA[i], RE[i]);
  endtask : t_reset
  task t_sample;
    gyro_y = 16'h1234;
    gyro_z = 16'h5678;
    step_total = 16'h9ABC;
    sample_strobe = 1'b1;
    @(negedge clk);
    sample_strobe = 1'b0;
    gyro_y = 16'hFFFF;
    gyro_z = 16'hFFFF;
    step_total = 16'hFFFF;
    rd(8'h27, 8'h12);
    rd(8'h28, 8'h34);
    rd(8'h29, 8'h56);
    rd(8'h2A, 8'h78);
    rd(8'h31, 8'hBC);
    rd(8'h32, 8'h9A);
  endtask : t_sample
  task t_events;
    for (int i = 0; i < 4; i++) begin
      evt = 4'h1 << i;
      @(negedge clk);
      evt = 4'h0;
      rd(8'h2D, EB[i]);
      rd(8'h2D, 8'h00);
    end
  endtask : t_events
  task sync_tick(input int n);
    fs = 1'b1;
    repeat (n) @(negedge clk);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    fs = 1'b0;
    repeat (2) @(negedge clk);
  endtask : sync_tick
  task t_sync;
    sync_tick(300);
    sync_tick(10);
    rd(8'h2C, 8'h2B);
    rd(8'h2B, 8'h01);
    rd(8'h2D, 8'h40);
    sync_tick(5);
    rd(8'h2C, 8'h04);
    rd(8'h2D, 8'h40);
    fs = 1'b1;
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    fs = 1'b0;
    rd(8'h2D, 8'h00);
  endtask : t_sync
  task t_enable;
    clk_en = 1'b0;
    evt = 4'h1;
    rd_addr = 8'h2D;
    rd_en = 1'b1;
    repeat (2) @(negedge clk);
    checked++;
    if (rd_valid !== 1'b0 || pop !== 1'b0) begin
      errors++;
      $display("mismatch %0t read taken while clock enable low", $time);
    end
    clk_en = 1'b1;
    evt = 4'h0;
    rd_en = 1'b0;
    @(negedge clk);
    rd(8'h2D, 8'h00);
  endtask : t_enable
  task t_queue;
    lus = 1'b1;
    push = 1'b1;
    for (int i = 0; i < 4; i++) begin
      pdat = QD[i];
      @(negedge clk);
    end
    push = 1'b0;
    @(negedge clk);
    rd(8'h2D, 8'h06);
    rd(8'h2F, 8'h04);
    rd(8'h2E, 8'h00);
    lus = 1'b0;
    rd(8'h2F, 8'h00);
    rd(8'h30, QD[0]);
    rd(8'h2E, 8'h04);
    for (int i = 1; i < 4; i++) rd(8'h30, QD[i]);
    rd(8'h30, 8'hFF);
    rd(8'h2F, 8'h00);
    rd(8'h2E, 8'h00);
  endtask : t_queue
  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    {rd_en, sample_strobe, fs, tick, lus, push} = 6'h00;
    {rd_addr, pdat, evt} = 20'h00000;
    {gyro_y, gyro_z, step_total} = 48'h000000000000;
    thr = 16'h0002;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_sample();
    t_events();
    t_enable();
    t_sync();
    t_queue();
    finish_test();
  end
endmodule : sosr_regs_tb

// [pkg/sosr_defines.svh]
`ifndef SOSR_DEFINES_SVH
`define SOSR_DEFINES_SVH

// Register addresses on the host interface.
`define SOSR_ADDR_GYRO_Y_HIGH 8'h27
`define SOSR_ADDR_GYRO_Y_LOW 8'h28
`define SOSR_ADDR_GYRO_Z_HIGH 8'h29
`define SOSR_ADDR_GYRO_Z_LOW 8'h2A
`define SOSR_ADDR_SYNC_STAMP_HIGH 8'h2B
`define SOSR_ADDR_SYNC_STAMP_LOW 8'h2C
`define SOSR_ADDR_EVENT_FLAGS 8'h2D
`define SOSR_ADDR_QUEUE_LEVEL_HIGH 8'h2E
`define SOSR_ADDR_QUEUE_LEVEL_LOW 8'h2F
`define SOSR_ADDR_QUEUE_READ_PORT 8'h30
`define SOSR_ADDR_STEP_TOTAL_LOW 8'h31
`define SOSR_ADDR_STEP_TOTAL_HIGH 8'h32

// Reset values, and the delta counter's saturation limit and step.
`define SOSR_RST_GYRO_HIGH 8'h80
`define SOSR_RST_BYTE 8'h00
`define SOSR_RST_EVENT_FLAGS 8'h10
`define SOSR_RST_QUEUE_PORT 8'hFF
`define SOSR_RST_WORD 16'h0000
`define SOSR_DELTA_MAX 16'hFFFF
`define SOSR_DELTA_ONE 16'h0001

// Bit positions in the event flag register.
`define SOSR_BIT_SYNC 6
`define SOSR_BIT_PLL 5
`define SOSR_BIT_RESET_DONE 4
`define SOSR_BIT_DATA_READY 3
`define SOSR_BIT_QUEUE_THRESHOLD 2
`define SOSR_BIT_QUEUE_FULL 1
`define SOSR_BIT_GAIN_READY 0
`define SOSR_BIT_RESERVED 7

`endif

// [pkg/sosr_pkg.sv]
package sosr_pkg;

  typedef struct packed {
    logic [7:0] gyro_y_high;
    logic [7:0] gyro_y_low;
    logic [7:0] gyro_z_high;
    logic [7:0] gyro_z_low;
    logic [7:0] step_high;
    logic [7:0] step_low;
    logic [15:0] stamp;
    logic stamp_locked;
    logic [15:0] delta_cnt;
    logic sync_armed;
    logic sync_prev;
    logic [7:0] flags;
    logic [7:0] level_high;
    logic [7:0] level_low;
    logic full_prev;
    logic thr_prev;
    logic [7:0] rd_data;
    logic rd_valid;
    logic queue_pop;
  } sosr_state_type;

endpackage : sosr_pkg

// [rtl/sosr_regs.sv]
`timescale 1ns/1ps
`include "sosr_defines.svh"
// What this block does
// R1: Lower gyro Y byte readable at 28h, resets to zero.
// R2: Upper gyro Z byte readable at 29h, resets to 80h.
// R3: Lower gyro Z byte readable at 2Ah, resets to zero.
// R4: Time from frame sync rising edge to the first sample tick after it; upper byte at 2Bh.
// R5: Lower delta byte at 2Ch; delta frozen until event flags are read.
// R6: Event flag register at 2Dh resets to 10h; bit 7 reserved.
// R7: Bit 6 sets when a sample tick captures the frame sync delta.
// R8: Bit 5 sets on every clock synthesizer ready event; the code drops one that comes while clk_en is low.
// R9: Bit 4 sets when software reset completes.
// R10: Bit 3 sets on every new sample ready event; the code drops one that comes while clk_en is low.
// R11: Bit 2 sets when queue level reaches programmed threshold.
// R12: Bit 1 sets when the queue becomes full.
// R13: Bit 0 sets on every gain control ready event; the code drops one that comes while clk_en is low.
// R14: Reading the event flag register clears all its flags.
// R15: Queue level is 16 bits at 2Eh/2Fh, records or bytes by unit select.
// R16: Reading the lower level byte snapshots the level into both bytes.
// R17: Host reads lower level byte first, then the upper byte.
// R18: Lower step total byte readable at 31h, resets to zero.
// R19: Upper step total byte readable at 32h.
// R20: Upper gyro Y byte readable at 27h.
// R21: Each queue port read at 30h returns and removes the next byte; resets FFh.
// R22: Both bytes of each sensor value come from the same sample.
module sosr_regs
  import sosr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic sample_strobe,
  input wire logic [15:0] gyro_y,
  input wire logic [15:0] gyro_z,
  input wire logic [15:0] step_total,
  input wire logic frame_sync_input,
  input wire logic output_sample_rate_tick,
  input wire logic pll_ready_evt,
  input wire logic soft_reset_done_evt,
  input wire logic data_ready_evt,
  input wire logic gain_ready_evt,
  input wire logic level_unit_select,
  input wire logic [15:0] queue_records,
  input wire logic [15:0] queue_bytes,
  input wire logic [15:0] queue_threshold,
  input wire logic queue_full,
  input wire logic queue_empty,
  input wire logic [7:0] queue_head,
  output logic queue_pop
);

  // ****************************************************************
  // State
  // ****************************************************************
  sosr_state_type state_r;
  sosr_state_type state_nxt;
  logic rd_flags;
  logic rd_level_low;
  logic sync_rise;
  logic capture_stamp;
  logic thr_now;
  logic [15:0] level_sel;
  logic [7:0] evt_vec;

  always_comb begin
    level_sel = level_unit_select ? queue_records : queue_bytes; // [R15]
    thr_now = (level_sel >= queue_threshold);
    rd_flags = rd_en && (rd_addr == `SOSR_ADDR_EVENT_FLAGS);
    rd_level_low = rd_en && (rd_addr == `SOSR_ADDR_QUEUE_LEVEL_LOW);
    sync_rise = frame_sync_input && !state_r.sync_prev;
    // A tick in the cycle of a new edge restarts the count and captures nothing.
    capture_stamp = output_sample_rate_tick && state_r.sync_armed && !state_r.stamp_locked &&
      !sync_rise;
    evt_vec = 8'h00;
    evt_vec[`SOSR_BIT_SYNC] = capture_stamp; // [R7]
    evt_vec[`SOSR_BIT_PLL] = pll_ready_evt; // [R8]
    evt_vec[`SOSR_BIT_RESET_DONE] = soft_reset_done_evt; // [R9]
    evt_vec[`SOSR_BIT_DATA_READY] = data_ready_evt; // [R10]
    evt_vec[`SOSR_BIT_QUEUE_THRESHOLD] = thr_now && !state_r.thr_prev; // [R11]
    evt_vec[`SOSR_BIT_QUEUE_FULL] = queue_full && !state_r.full_prev; // [R12]
    evt_vec[`SOSR_BIT_GAIN_READY] = gain_ready_evt; // [R13]
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    state_nxt.rd_valid = rd_en;
    state_nxt.queue_pop = 1'b0;
    state_nxt.sync_prev = frame_sync_input;
    state_nxt.full_prev = queue_full;
    state_nxt.thr_prev = thr_now;

    // Both bytes of each value are loaded on the same strobe.
    if (sample_strobe) begin // [R22]
      state_nxt.gyro_y_high = gyro_y[15:8]; // [R20]
      state_nxt.gyro_y_low = gyro_y[7:0]; // [R1]
      state_nxt.gyro_z_high = gyro_z[15:8]; // [R2]
      state_nxt.gyro_z_low = gyro_z[7:0]; // [R3]
      state_nxt.step_high = step_total[15:8]; // [R19]
      state_nxt.step_low = step_total[7:0]; // [R18]
    end

    // The delta counts clock cycles from the last frame sync rising edge.
    if (sync_rise) begin // [R4]
      state_nxt.delta_cnt = `SOSR_RST_WORD;
      state_nxt.sync_armed = 1'b1;
    end else if (state_r.sync_armed && state_r.delta_cnt != `SOSR_DELTA_MAX) begin
      state_nxt.delta_cnt = state_r.delta_cnt + `SOSR_DELTA_ONE;
    end
    if (capture_stamp && !sync_rise) begin // [R4]
      state_nxt.stamp = state_r.delta_cnt;
      state_nxt.stamp_locked = 1'b1;
      state_nxt.sync_armed = 1'b0;
    end

    // A read acknowledges the flags; an event in the same cycle survives.
    if (rd_flags) begin // [R14]
      state_nxt.flags = evt_vec;
      // A capture in the cycle of the read stays frozen, so its new flag and delta agree.
      state_nxt.stamp_locked = capture_stamp; // [R5]
    end else begin
      state_nxt.flags = state_r.flags | evt_vec;
    end

    if (rd_level_low) begin // [R16]
      state_nxt.level_high = level_sel[15:8];
      state_nxt.level_low = level_sel[7:0];
    end

    state_nxt.rd_data = `SOSR_RST_BYTE;
    if (rd_en) begin
      case (rd_addr)
        `SOSR_ADDR_GYRO_Y_HIGH: state_nxt.rd_data = state_r.gyro_y_high; // [R20]
        `SOSR_ADDR_GYRO_Y_LOW: state_nxt.rd_data = state_r.gyro_y_low; // [R1]
        `SOSR_ADDR_GYRO_Z_HIGH: state_nxt.rd_data = state_r.gyro_z_high; // [R2]
        `SOSR_ADDR_GYRO_Z_LOW: state_nxt.rd_data = state_r.gyro_z_low; // [R3]
        `SOSR_ADDR_SYNC_STAMP_HIGH: state_nxt.rd_data = state_r.stamp[15:8]; // [R4]
        `SOSR_ADDR_SYNC_STAMP_LOW: state_nxt.rd_data = state_r.stamp[7:0]; // [R5]
        `SOSR_ADDR_EVENT_FLAGS: state_nxt.rd_data = state_r.flags; // [R6]
        // Upper byte holds the snapshot made by the last lower byte read.
        `SOSR_ADDR_QUEUE_LEVEL_HIGH: state_nxt.rd_data = state_r.level_high; // [R17]
        `SOSR_ADDR_QUEUE_LEVEL_LOW: state_nxt.rd_data = level_sel[7:0]; // [R16]
        `SOSR_ADDR_QUEUE_READ_PORT: begin // [R21]
          if (queue_empty) begin
            state_nxt.rd_data = `SOSR_RST_QUEUE_PORT;
          end else begin
            state_nxt.rd_data = queue_head;
            state_nxt.queue_pop = 1'b1;
          end
        end
        `SOSR_ADDR_STEP_TOTAL_LOW: state_nxt.rd_data = state_r.step_low; // [R18]
        `SOSR_ADDR_STEP_TOTAL_HIGH: state_nxt.rd_data = state_r.step_high; // [R19]
        default: state_nxt.rd_data = `SOSR_RST_BYTE;
      endcase
    end
    state_nxt.flags[`SOSR_BIT_RESERVED] = 1'b0; // [R6]
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r.gyro_y_high <= `SOSR_RST_GYRO_HIGH;
      state_r.gyro_y_low <= `SOSR_RST_BYTE; // [R1]
      state_r.gyro_z_high <= `SOSR_RST_GYRO_HIGH; // [R2]
      state_r.gyro_z_low <= `SOSR_RST_BYTE; // [R3]
      state_r.step_high <= `SOSR_RST_BYTE;
      state_r.step_low <= `SOSR_RST_BYTE; // [R18]
      state_r.stamp <= `SOSR_RST_WORD;
      state_r.stamp_locked <= 1'b0;
      state_r.delta_cnt <= `SOSR_RST_WORD;
      state_r.sync_armed <= 1'b0;
      state_r.sync_prev <= 1'b0;
      state_r.flags <= `SOSR_RST_EVENT_FLAGS; // [R6]
      state_r.level_high <= `SOSR_RST_BYTE;
      state_r.level_low <= `SOSR_RST_BYTE;
      state_r.full_prev <= 1'b0;
      state_r.thr_prev <= 1'b0;
      state_r.rd_data <= `SOSR_RST_QUEUE_PORT; // [R21]
      state_r.rd_valid <= 1'b0;
      state_r.queue_pop <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  assign rd_data = state_r.rd_data;
  assign rd_valid = state_r.rd_valid;
  assign queue_pop = state_r.queue_pop;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_FLAGS_CLEAR: assert property (@(posedge clk) disable iff (!resetn) // [R14]
    clk_en && rd_flags && evt_vec == 8'h00 |=> state_r.flags == 8'h00)
    else $error("Event flags not cleared by a read.");

  AST_FLAGS_READ: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    clk_en && rd_flags |=> rd_data == $past(state_r.flags) && !rd_data[7])
    else $error("Event flag read returned the wrong value.");

  AST_SYNC_SET: assert property (@(posedge clk) disable iff (!resetn) // [R7]
    clk_en && capture_stamp |=> state_r.flags[`SOSR_BIT_SYNC] && state_r.stamp_locked)
    else $error("Frame sync capture did not set its flag.");

  AST_STAMP_FROZEN: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    state_r.stamp_locked && !(clk_en && rd_flags) |=> $stable(state_r.stamp))
    else $error("Stamp changed while frozen.");

  AST_DELTA_VALUE: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    clk_en && capture_stamp && !sync_rise |=> state_r.stamp == $past(state_r.delta_cnt))
    else $error("Stamp does not hold the counted delta.");

  AST_FULL_SET: assert property (@(posedge clk) disable iff (!resetn) // [R12]
    clk_en && queue_full && !state_r.full_prev |=> state_r.flags[`SOSR_BIT_QUEUE_FULL])
    else $error("Queue full did not set its flag.");

  AST_RESET_DONE_SET: assert property (@(posedge clk) disable iff (!resetn) // [R9]
    clk_en && soft_reset_done_evt |=> state_r.flags[`SOSR_BIT_RESET_DONE])
    else $error("Reset done did not set its flag.");

  AST_LEVEL_SNAP: assert property (@(posedge clk) disable iff (!resetn) // [R16]
    clk_en && rd_level_low |=>
      {state_r.level_high, state_r.level_low} == $past(level_sel) &&
      rd_data == state_r.level_low)
    else $error("Queue level snapshot incoherent.");

  AST_SAMPLE_PAIR: assert property (@(posedge clk) disable iff (!resetn) // [R22]
    clk_en && sample_strobe |=>
      {state_r.gyro_z_high, state_r.gyro_z_low} == $past(gyro_z) &&
      {state_r.gyro_y_high, state_r.gyro_y_low} == $past(gyro_y))
    else $error("Sensor bytes not loaded from one sample.");

  AST_QUEUE_POP: assert property (@(posedge clk) disable iff (!resetn) // [R21]
    clk_en && rd_en && rd_addr == `SOSR_ADDR_QUEUE_READ_PORT && !queue_empty |=>
      queue_pop && rd_data == $past(queue_head))
    else $error("Queue port read did not pop the head byte.");

  AST_GYRO_Y_HIGH_READ: assert property (@(posedge clk) disable iff (!resetn) // [R20]
    clk_en && rd_en && rd_addr == `SOSR_ADDR_GYRO_Y_HIGH |=>
      rd_valid && rd_data == $past(state_r.gyro_y_high))
    else $error("Upper gyro Y byte read wrong.");

  AST_GYRO_Y_LOW_READ: assert property (@(posedge clk) disable iff (!resetn) // [R1]
    clk_en && rd_en && rd_addr == `SOSR_ADDR_GYRO_Y_LOW |=>
      rd_valid && rd_data == $past(state_r.gyro_y_low))
    else $error("Lower gyro Y byte read wrong.");

  AST_GYRO_Z_HIGH_READ: assert property (@(posedge clk) disable iff (!resetn) // [R2]
    clk_en && rd_en && rd_addr == `SOSR_ADDR_GYRO_Z_HIGH |=>
      rd_valid && rd_data == $past(state_r.gyro_z_high))
    else $error("Upper gyro Z byte read wrong.");

  AST_GYRO_Z_LOW_READ: assert property (@(posedge clk) disable iff (!resetn) // [R3]
    clk_en && rd_en && rd_addr == `SOSR_ADDR_GYRO_Z_LOW |=>
      rd_valid && rd_data == $past(state_r.gyro_z_low))
    else $error("Lower gyro Z byte read wrong.");

  AST_STAMP_HIGH_READ: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    clk_en && rd_en && rd_addr == `SOSR_ADDR_SYNC_STAMP_HIGH |=>
      rd_valid && rd_data == $past(state_r.stamp[15:8]))
    else $error("Upper stamp byte read wrong.");

  AST_STAMP_LOW_READ: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    clk_en && rd_en && rd_addr == `SOSR_ADDR_SYNC_STAMP_LOW |=>
      rd_valid && rd_data == $past(state_r.stamp[7:0]))
    else $error("Lower stamp byte read wrong.");

  AST_SYNC_RESTART: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    clk_en && sync_rise |=>
      state_r.delta_cnt == `SOSR_RST_WORD && state_r.sync_armed)
    else $error("Frame sync edge did not restart the delta.");

  AST_DELTA_COUNT: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    clk_en && state_r.sync_armed && !sync_rise && state_r.delta_cnt != `SOSR_DELTA_MAX |=>
      state_r.delta_cnt == $past(state_r.delta_cnt) + `SOSR_DELTA_ONE)
    else $error("Frame sync delta did not advance by one.");

  AST_PLL_SET: assert property (@(posedge clk) disable iff (!resetn) // [R8]
    clk_en && pll_ready_evt |=>
      state_r.flags[`SOSR_BIT_PLL])
    else $error("Clock synthesizer ready did not set its flag.");

  AST_DATA_READY_SET: assert property (@(posedge clk) disable iff (!resetn) // [R10]
    clk_en && data_ready_evt |=>
      state_r.flags[`SOSR_BIT_DATA_READY])
    else $error("New sample ready did not set its flag.");

  AST_THRESHOLD_SET: assert property (@(posedge clk) disable iff (!resetn) // [R11]
    clk_en && thr_now && !state_r.thr_prev |=>
      state_r.flags[`SOSR_BIT_QUEUE_THRESHOLD])
    else $error("Queue threshold did not set its flag.");

  AST_GAIN_READY_SET: assert property (@(posedge clk) disable iff (!resetn) // [R13]
    clk_en && gain_ready_evt |=>
      state_r.flags[`SOSR_BIT_GAIN_READY])
    else $error("Gain control ready did not set its flag.");

  AST_LEVEL_RECORDS: assert property (@(posedge clk) disable iff (!resetn) // [R15]
    clk_en && rd_level_low && level_unit_select |=>
      {state_r.level_high, state_r.level_low} == $past(queue_records))
    else $error("Queue level in records captured wrong.");

  AST_LEVEL_BYTES: assert property (@(posedge clk) disable iff (!resetn) // [R15]
    clk_en && rd_level_low && !level_unit_select |=>
      {state_r.level_high, state_r.level_low} == $past(queue_bytes))
    else $error("Queue level in bytes captured wrong.");

  AST_LEVEL_HIGH_READ: assert property (@(posedge clk) disable iff (!resetn) // [R16]
    clk_en && rd_en && rd_addr == `SOSR_ADDR_QUEUE_LEVEL_HIGH |=>
      rd_valid && rd_data == $past(state_r.level_high))
    else $error("Upper queue level byte is not the snapshot.");

  AST_STEP_LOW_READ: assert property (@(posedge clk) disable iff (!resetn) // [R18]
    clk_en && rd_en && rd_addr == `SOSR_ADDR_STEP_TOTAL_LOW |=>
      rd_valid && rd_data == $past(state_r.step_low))
    else $error("Lower step total byte read wrong.");

  AST_STEP_HIGH_READ: assert property (@(posedge clk) disable iff (!resetn) // [R19]
    clk_en && rd_en && rd_addr == `SOSR_ADDR_STEP_TOTAL_HIGH |=>
      rd_valid && rd_data == $past(state_r.step_high))
    else $error("Upper step total byte read wrong.");

  AST_STEP_PAIR: assert property (@(posedge clk) disable iff (!resetn) // [R22]
    clk_en && sample_strobe |=>
      {state_r.step_high, state_r.step_low} == $past(step_total))
    else $error("Step total bytes not loaded from one sample.");

  AST_QUEUE_EMPTY_READ: assert property (@(posedge clk) disable iff (!resetn) // [R21]
    clk_en && rd_en && rd_addr == `SOSR_ADDR_QUEUE_READ_PORT && queue_empty |=>
      rd_data == `SOSR_RST_QUEUE_PORT && !queue_pop)
    else $error("Empty queue port read returned data or popped.");

  AST_FREEZE: assert property (@(posedge clk) disable iff (!resetn) // [R14]
    !clk_en |=>
      $stable(state_r.flags) && $stable(rd_valid) && $stable(queue_pop) && $stable(rd_data))
    else $error("State moved while the clock enable was low.");

endmodule : sosr_regs
